// file: core/ptps_defs.vh
`ifndef PTPS_DEFS_VH
`define PTPS_DEFS_VH

// ****************************************
// Clock and timing
// ****************************************
`define PTPS_CLK_MHZ 125
`define PTPS_MS_CYCLES (`PTPS_CLK_MHZ * 1000)

// ****************************************
// Register byte addresses
// ****************************************
`define PTPS_ADDR_PARAM 12'h000
`define PTPS_ADDR_GEAR_NUM 12'h004
`define PTPS_ADDR_GEAR_DEN 12'h008
`define PTPS_ADDR_STATUS 12'h00c
`define PTPS_TABLE_BASE_BIT 9

// ****************************************
// Parameter register fields and reset values
// ****************************************
`define PTPS_F_METHOD 0
`define PTPS_F_UNIT_LO 4
`define PTPS_F_STM_LO 8
`define PTPS_F_ROT_DIR 12
`define PTPS_F_FILT_LO 16
`define PTPS_PARAM_RST 32'h0000_0000
`define PTPS_PARAM_MASK 32'h000f_1331
`define PTPS_GEAR_RST 32'h0000_0001

// ****************************************
// Table entry words and fields
// ****************************************
`define PTPS_W_POS 2'h0
`define PTPS_W_SPEED 2'h1
`define PTPS_W_ACCDEC 2'h2
`define PTPS_W_DWAUX 2'h3
`define PTPS_POS_MAX 20'hf423f
`define PTPS_LAST_ENTRY 5'h1f

// ****************************************
// Units and auxiliary codes
// ****************************************
`define PTPS_UNIT_MM 2'h0
`define PTPS_UNIT_INCH 2'h1
`define PTPS_AUX_ABS_STOP 4'h0
`define PTPS_AUX_ABS_CONT 4'h1
`define PTPS_AUX_INC_STOP 4'h2
`define PTPS_AUX_INC_CONT 4'h3

`endif

// file: core/ptps_in_filter.v
`timescale 1ns/1ps
`include "ptps_defs.vh"

module ptps_in_filter (
  input wire i_sys_clk,
  input wire i_rst_n,
  input wire i_ms_tick,
  input wire [3:0] i_filter_ms,
  input wire [7:0] i_pins,
  output reg [7:0] o_clean
);

  // ****************************************
  // Three-stage synchroniser
  // ****************************************
  reg [7:0] sync1_reg;
  reg [7:0] sync2_reg;
  reg [7:0] sync3_reg;
  reg [7:0] agreed_reg;
  reg [3:0] stable_reg;

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
      sync3_reg <= 8'h00;
    end else begin
      sync1_reg <= i_pins;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // ****************************************
  // Filter delay
  // ****************************************
  // A bit only counts as changed once stages two and three agree
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      agreed_reg <= 8'h00;
      stable_reg <= 4'h0;
      o_clean <= 8'h00;
    end else begin
      if ((sync2_reg & sync3_reg) != agreed_reg &&
          (sync2_reg ~^ sync3_reg) == 8'hff) begin
        agreed_reg <= sync3_reg;
        stable_reg <= 4'h0;
      end else if (i_ms_tick && stable_reg != 4'hf) begin
        stable_reg <= stable_reg + 4'h1;
      end
      // Inputs reach the sequencer only after the set filter time [RQ10]
      if (stable_reg >= i_filter_ms) begin
        o_clean <= agreed_reg;
      end
    end
  end

endmodule

// file: core/ptps_sequencer.v
// Function
// [RQ1] Position data unit follows unit digit: 0 mm, 1 inch, 2 degree, 3 pulse.
// [RQ2] Millimetre and inch data scale by feed multiplier 0 to 3.
// [RQ3] Degree and pulse data never use feed multiplier; gear scales pulses.
// [RQ4] Point-table operation only while automatic mode select is asserted; code checks it only at start, a running chain continues.
// [RQ5] Table select picks entry; forward start moves it with entry profile.
// [RQ6] Incremental method: reverse start moves selected entry in reverse.
// [RQ7] Incremental chained runs keep one direction only.
// [RQ8] Start accepted only stopped and servo on; absolute method forward only.
// [RQ9] Method digit 1: forward or reverse start begins positioning.
// [RQ10] Controller sets table select before start; inputs pass filter delay.
// [RQ11] One start steps through consecutively numbered entries from selected one.
// [RQ12] Absolute method: aux 1 absolute, 3 incremental, both continue.
// [RQ13] Chain ends at aux 0 or 2; device stops there.
// [RQ14] Only four table-number output bits are presented at once.
// [RQ15] Next entry starts after completion plus dwell time.
// [RQ16] Direction parameter maps forward to CCW (0) or CW (1) increasing.
// [RQ17] Continue code on entry 31 raises an error.
// [RQ18] Each start is a filtered rising edge launching one sequence.
`timescale 1ns/1ps
`include "ptps_defs.vh"

module ptps_sequencer #(
  parameter MS_CYCLES = `PTPS_MS_CYCLES
) (
  input wire i_sys_clk,
  input wire i_rst_n,
  input wire [11:0] i_s_axi_awaddr,
  input wire i_s_axi_awvalid,
  output wire o_s_axi_awready,
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  input wire i_s_axi_wvalid,
  output wire o_s_axi_wready,
  output reg [1:0] o_s_axi_bresp,
  output reg o_s_axi_bvalid,
  input wire i_s_axi_bready,
  input wire [11:0] i_s_axi_araddr,
  input wire i_s_axi_arvalid,
  output wire o_s_axi_arready,
  output reg [31:0] o_s_axi_rdata,
  output reg [1:0] o_s_axi_rresp,
  output reg o_s_axi_rvalid,
  input wire i_s_axi_rready,
  input wire i_auto_mode_select_in,
  input wire [4:0] i_table_select_in,
  input wire i_forward_start_in,
  input wire i_reverse_start_in,
  input wire i_motor_stopped,
  input wire i_servo_on,
  input wire i_move_done,
  output reg o_move_start,
  output reg [29:0] o_move_distance,
  output reg o_move_absolute,
  output reg o_move_increase,
  output reg o_move_ccw,
  output reg [1:0] o_move_unit,
  output reg [15:0] o_move_speed,
  output reg [15:0] o_move_accel,
  output reg [15:0] o_move_decel,
  output reg [3:0] o_table_number_out,
  output wire o_busy,
  output reg o_error,
  output wire [31:0] o_gear_numerator_param,
  output wire [31:0] o_gear_denominator_param
);

  // ****************************************
  // Functions
  // ****************************************
  function [31:0] merge_bytes;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    integer k;
    begin
      merge_bytes = old_val;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          merge_bytes[k*8 +: 8] = new_val[k*8 +: 8];
        end
      end
    end
  endfunction

  function [29:0] scale_pos;
    input [19:0] pos;
    input [1:0] unit;
    input [1:0] feed_multiplier_factor;
    reg [29:0] x;
    begin
      x = {10'h000, pos};
      if (unit == `PTPS_UNIT_MM || unit == `PTPS_UNIT_INCH) begin // [RQ2]
        case (feed_multiplier_factor)
          2'h1: x = x * 30'h000000a;
          2'h2: x = x * 30'h0000064;
          2'h3: x = x * 30'h00003e8;
          default: x = x;
        endcase
      end
      scale_pos = x; // [RQ3]
    end
  endfunction

  // ****************************************
  // Millisecond enable
  // ****************************************
  reg [16:0] div_reg;
  wire ms_tick = (div_reg == MS_CYCLES - 1);

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_reg <= 17'h00000;
    end else if (ms_tick) begin
      div_reg <= 17'h00000;
    end else begin
      div_reg <= div_reg + 17'h00001;
    end
  end

  // ****************************************
  // Registers and point table
  // ****************************************
  reg [31:0] param_reg;
  reg [31:0] gear_num_reg;
  reg [31:0] gear_den_reg;
  reg [31:0] tbl [0:127];
  reg [2:0] state_reg;
  reg [4:0] entry_reg;

  wire method_inc = param_reg[`PTPS_F_METHOD];
  wire [1:0] unit = param_reg[`PTPS_F_UNIT_LO +: 2];
  wire [1:0] feed_multiplier_factor = param_reg[`PTPS_F_STM_LO +: 2];
  wire rot_dir = param_reg[`PTPS_F_ROT_DIR];
  wire [3:0] filt_ms = param_reg[`PTPS_F_FILT_LO +: 4];

  assign o_gear_numerator_param = gear_num_reg;
  assign o_gear_denominator_param = gear_den_reg;

  // Both write channels are taken together so no address buffer is needed
  wire wr_go = i_s_axi_awvalid && i_s_axi_wvalid && !o_s_axi_bvalid;
  assign o_s_axi_awready = wr_go;
  assign o_s_axi_wready = wr_go;
  assign o_s_axi_arready = !o_s_axi_rvalid;
  wire rd_go = i_s_axi_arvalid && !o_s_axi_rvalid;
  wire wr_tbl = i_s_axi_awaddr[11:`PTPS_TABLE_BASE_BIT] == 3'h1;
  wire rd_tbl = i_s_axi_araddr[11:`PTPS_TABLE_BASE_BIT] == 3'h1;
  wire [6:0] wr_idx = i_s_axi_awaddr[8:2];
  wire [31:0] tbl_merged = merge_bytes(tbl[wr_idx], i_s_axi_wdata, i_s_axi_wstrb);

  always @(posedge i_sys_clk) begin
    if (wr_go && wr_tbl) begin
      // Out-of-range position data clamps to the maximum
      if (wr_idx[1:0] == `PTPS_W_POS && tbl_merged[31:0] > {12'h000, `PTPS_POS_MAX}) begin
        tbl[wr_idx] <= {12'h000, `PTPS_POS_MAX};
      end else begin
        tbl[wr_idx] <= tbl_merged;
      end
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      param_reg <= `PTPS_PARAM_RST;
      gear_num_reg <= `PTPS_GEAR_RST;
      gear_den_reg <= `PTPS_GEAR_RST;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= 2'h0;
    end else begin
      if (wr_go) begin
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= 2'h0;
        if (wr_tbl) begin
          o_s_axi_bresp <= 2'h0;
        end else if (i_s_axi_awaddr == `PTPS_ADDR_PARAM) begin
          param_reg <= merge_bytes(param_reg, i_s_axi_wdata, i_s_axi_wstrb) &
                       `PTPS_PARAM_MASK;
        end else if (i_s_axi_awaddr == `PTPS_ADDR_GEAR_NUM) begin
          gear_num_reg <= merge_bytes(gear_num_reg, i_s_axi_wdata, i_s_axi_wstrb);
        end else if (i_s_axi_awaddr == `PTPS_ADDR_GEAR_DEN) begin
          gear_den_reg <= merge_bytes(gear_den_reg, i_s_axi_wdata, i_s_axi_wstrb);
        end else if (i_s_axi_awaddr != `PTPS_ADDR_STATUS) begin
          o_s_axi_bresp <= 2'h2;
        end
      end else if (i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0000_0000;
      o_s_axi_rresp <= 2'h0;
    end else if (rd_go) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rresp <= 2'h0;
      if (rd_tbl) begin
        o_s_axi_rdata <= tbl[i_s_axi_araddr[8:2]];
      end else if (i_s_axi_araddr == `PTPS_ADDR_PARAM) begin
        o_s_axi_rdata <= param_reg;
      end else if (i_s_axi_araddr == `PTPS_ADDR_GEAR_NUM) begin
        o_s_axi_rdata <= gear_num_reg;
      end else if (i_s_axi_araddr == `PTPS_ADDR_GEAR_DEN) begin
        o_s_axi_rdata <= gear_den_reg;
      end else if (i_s_axi_araddr == `PTPS_ADDR_STATUS) begin
        o_s_axi_rdata <= {14'h0000, o_busy, o_error, 3'h0, entry_reg, 5'h00, state_reg};
      end else begin
        o_s_axi_rdata <= 32'h0000_0000;
        o_s_axi_rresp <= 2'h2;
      end
    end else if (i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Input filter and start edges
  // ****************************************
  wire [7:0] clean;
  reg fwd_prev_reg;
  reg rev_prev_reg;

  ptps_in_filter u_filter (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_ms_tick(ms_tick),
    .i_filter_ms(filt_ms),
    .i_pins({i_reverse_start_in, i_forward_start_in, i_auto_mode_select_in,
             i_table_select_in}),
    .o_clean(clean)
  );

  wire [4:0] sel = clean[4:0];
  wire auto_mode = clean[5];
  wire fwd_edge = clean[6] && !fwd_prev_reg; // [RQ18]
  wire rev_edge = clean[7] && !rev_prev_reg; // [RQ18]

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fwd_prev_reg <= 1'b0;
      rev_prev_reg <= 1'b0;
    end else begin
      fwd_prev_reg <= clean[6];
      rev_prev_reg <= clean[7];
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  localparam S_IDLE = 3'h0;
  localparam S_LOAD = 3'h1;
  localparam S_MOVE = 3'h2;
  localparam S_DWELL = 3'h3;
  localparam S_ERR = 3'h4;

  reg run_fwd_reg;
  reg cont_reg;
  reg [15:0] dwell_reg;
  reg [15:0] dwell_cnt_reg;

  wire [31:0] w_pos = tbl[{entry_reg, `PTPS_W_POS}];
  wire [31:0] w_spd = tbl[{entry_reg, `PTPS_W_SPEED}];
  wire [31:0] w_acd = tbl[{entry_reg, `PTPS_W_ACCDEC}];
  wire [31:0] w_dwa = tbl[{entry_reg, `PTPS_W_DWAUX}];
  wire [3:0] aux = w_dwa[19:16];
  // Absolute method honours both continue codes, incremental only code 1
  wire cont_now = method_inc ? (aux == `PTPS_AUX_ABS_CONT) :
                  (aux == `PTPS_AUX_ABS_CONT || aux == `PTPS_AUX_INC_CONT); // [RQ12] [RQ13]
  wire abs_now = !method_inc &&
                 (aux == `PTPS_AUX_ABS_STOP || aux == `PTPS_AUX_ABS_CONT); // [RQ12]
  // Reverse start only counts in the incremental method
  wire start_ok = auto_mode && i_motor_stopped && i_servo_on &&
                  (fwd_edge || (method_inc && rev_edge)); // [RQ4] [RQ8] [RQ9]

  assign o_busy = state_reg != S_IDLE && state_reg != S_ERR;

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= S_IDLE;
      entry_reg <= 5'h00;
      run_fwd_reg <= 1'b1;
      cont_reg <= 1'b0;
      dwell_reg <= 16'h0000;
      dwell_cnt_reg <= 16'h0000;
      o_error <= 1'b0;
      o_move_start <= 1'b0;
      o_move_distance <= 30'h00000000;
      o_move_absolute <= 1'b0;
      o_move_increase <= 1'b1;
      o_move_ccw <= 1'b1;
      o_move_unit <= 2'h0;
      o_move_speed <= 16'h0000;
      o_move_accel <= 16'h0000;
      o_move_decel <= 16'h0000;
      o_table_number_out <= 4'h0;
    end else begin
      o_move_start <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start_ok) begin
            entry_reg <= sel; // [RQ5]
            run_fwd_reg <= fwd_edge; // [RQ6]
            state_reg <= S_LOAD;
          end
        end
        S_LOAD: begin
          cont_reg <= cont_now;
          dwell_reg <= w_dwa[15:0];
          dwell_cnt_reg <= 16'h0000;
          if (cont_now && entry_reg == `PTPS_LAST_ENTRY) begin
            o_error <= 1'b1; // [RQ17]
            state_reg <= S_ERR;
          end else begin
            o_move_start <= 1'b1; // [RQ5]
            o_move_distance <= scale_pos(w_pos[19:0], unit, feed_multiplier_factor); // [RQ2] [RQ3]
            o_move_unit <= unit; // [RQ1]
            o_move_absolute <= abs_now;
            // Incremental moves keep the start direction for the whole chain
            o_move_increase <= abs_now | run_fwd_reg; // [RQ7]
            o_move_ccw <= (abs_now | run_fwd_reg) ^ rot_dir; // [RQ16]
            o_move_speed <= w_spd[15:0];
            o_move_accel <= w_acd[15:0];
            o_move_decel <= w_acd[31:16];
            state_reg <= S_MOVE;
          end
        end
        S_MOVE: begin
          if (i_move_done) begin
            o_table_number_out <= entry_reg[3:0]; // [RQ14]
            if (!cont_reg) begin
              state_reg <= S_IDLE; // [RQ13]
            end else if (dwell_reg == 16'h0000) begin
              entry_reg <= entry_reg + 5'h01; // [RQ11]
              state_reg <= S_LOAD;
            end else begin
              state_reg <= S_DWELL;
            end
          end
        end
        S_DWELL: begin
          if (ms_tick) begin
            dwell_cnt_reg <= dwell_cnt_reg + 16'h0001;
            if (dwell_cnt_reg + 16'h0001 >= dwell_reg) begin
              entry_reg <= entry_reg + 5'h01; // [RQ11] [RQ15]
              state_reg <= S_LOAD;
            end
          end
        end
        S_ERR: begin
          // Held until the controller leaves automatic mode
          if (!auto_mode) begin
            o_error <= 1'b0;
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// file: tb/ptps_sequencer_properties.sv
`timescale 1ns/1ps
module ptps_sequencer_properties (
  input wire i_sys_clk,
  input wire i_rst_n,
  input wire i_s_axi_awvalid,
  input wire i_s_axi_wvalid,
  input wire o_s_axi_awready,
  input wire o_s_axi_bvalid,
  input wire o_s_axi_rvalid,
  input wire i_s_axi_rready,
  input wire [31:0] o_s_axi_rdata,
  input wire i_motor_stopped,
  input wire i_servo_on,
  input wire i_move_done,
  input wire o_move_start,
  input wire [29:0] o_move_distance,
  input wire [1:0] o_move_unit,
  input wire o_busy,
  input wire o_error,
  input wire [3:0] o_table_number_out
);
  // ****************************************
  // Properties
  // ****************************************
  // Open from a start pulse until done, so a second start cannot overlap a move
  reg move_open_reg;
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      move_open_reg <= 1'b0;
    end else if (o_move_start) begin
      move_open_reg <= 1'b1;
    end else if (i_move_done) begin
      move_open_reg <= 1'b0;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  a_start_single_pulse: assert property (o_move_start |=> !o_move_start)
    else $error("move start longer than one cycle");
  a_start_when_ready: assert property ($rose(o_busy) |-> $past(i_motor_stopped) && $past(i_servo_on))
    else $error("sequence began while moving or servo off");
  a_start_in_busy: assert property (o_move_start |-> o_busy)
    else $error("move start outside a sequence");
  a_fields_with_start: assert property ($changed(o_move_distance) |-> o_move_start)
    else $error("distance changed without a start");
  a_next_after_done: assert property (o_move_start |-> !move_open_reg)
    else $error("next move before current one completed");
  a_table_out_done: assert property ($changed(o_table_number_out) |-> $past(i_move_done))
    else $error("table number changed without completion");
  a_error_no_motion: assert property (o_error |-> !o_move_start && !o_busy)
    else $error("motion while in error");
  a_raw_unit_range: assert property (o_move_start && o_move_unit[1] |-> o_move_distance <= 30'd999999)
    else $error("degree or pulse distance was scaled");
  a_scaled_range: assert property (o_move_start |-> o_move_distance <= 30'd999999000)
    else $error("distance beyond scaled range");
  a_bvalid_one_later: assert property (i_s_axi_awvalid && i_s_axi_wvalid && o_s_axi_awready
    |=> o_s_axi_bvalid) else $error("write response late");
  a_rvalid_stands: assert property (o_s_axi_rvalid && !i_s_axi_rready
    |=> o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read data dropped early");
endmodule

bind ptps_sequencer ptps_sequencer_properties u_props (.i_sys_clk, .i_rst_n, .i_s_axi_awvalid,
  .i_s_axi_wvalid, .o_s_axi_awready, .o_s_axi_bvalid, .o_s_axi_rvalid, .i_s_axi_rready,
  .o_s_axi_rdata, .i_motor_stopped, .i_servo_on, .i_move_done, .o_move_start,
  .o_move_distance, .o_move_unit, .o_busy, .o_error, .o_table_number_out);

// file: tb/ptps_ctrl_model.sv
`timescale 1ns/1ps
module ptps_ctrl_model #(
  parameter HOLD = 80
) (
  input wire i_sys_clk,
  output logic o_auto_mode,
  output logic [4:0] o_table_sel,
  output logic o_fwd,
  output logic o_rev
);
  initial begin
    o_auto_mode = 1'b0;
    o_table_sel = 5'h00;
    o_fwd = 1'b0;
    o_rev = 1'b0;
  end
  // Hold spans cover sync plus filter delay, else the select is read stale
  task automatic start(input logic auto, input logic fwd, input logic [4:0] e);
    o_auto_mode <= auto;
    o_table_sel <= e;
    repeat (HOLD) @(posedge i_sys_clk);
    if (fwd) o_fwd <= 1'b1;
    else o_rev <= 1'b1;
    repeat (HOLD) @(posedge i_sys_clk);
    o_fwd <= 1'b0;
    o_rev <= 1'b0;
  endtask
endmodule

// file: tb/ptps_sequencer_tb_top.sv
`timescale 1ns/1ps
module ptps_sequencer_tb_top;
  localparam MS = 20;
  logic i_sys_clk, i_rst_n, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid;
  logic i_s_axi_rready, i_motor_stopped, i_servo_on, i_move_done;
  logic [11:0] i_s_axi_awaddr, i_s_axi_araddr;
  logic [31:0] i_s_axi_wdata, g;
  logic [3:0] i_s_axi_wstrb;
  wire i_auto_mode_select_in, i_forward_start_in, i_reverse_start_in;
  wire [4:0] i_table_select_in;
  wire o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  wire o_move_start, o_move_absolute, o_move_increase, o_move_ccw, o_busy, o_error;
  wire [1:0] o_s_axi_bresp, o_s_axi_rresp, o_move_unit;
  wire [31:0] o_s_axi_rdata, o_gear_numerator_param, o_gear_denominator_param;
  wire [29:0] o_move_distance;
  wire [15:0] o_move_speed, o_move_accel, o_move_decel;
  wire [3:0] o_table_number_out;
  wire [82:0] seen_mv = {o_move_distance, o_move_absolute, o_move_increase, o_move_ccw,
    o_move_unit, o_move_speed, o_move_decel, o_move_accel};
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  int done_cyc = 0;
  logic [82:0] exp_q[$];
  int gap_q[$];
  logic [19:0] pos_a [0:31];
  logic [15:0] sp_a [0:31];
  logic [31:0] ad_a [0:31];
  logic [3:0] refuse [4] = '{4'b0111, 4'b1011, 4'b1101, 4'b1110};
  logic [1:0] s;

  ptps_sequencer #(.MS_CYCLES(MS)) u_dut (.i_sys_clk, .i_rst_n, .i_s_axi_awaddr,
    .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid,
    .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr,
    .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid,
    .i_s_axi_rready, .i_auto_mode_select_in, .i_table_select_in, .i_forward_start_in,
    .i_reverse_start_in, .i_motor_stopped, .i_servo_on, .i_move_done, .o_move_start,
    .o_move_distance, .o_move_absolute, .o_move_increase, .o_move_ccw, .o_move_unit,
    .o_move_speed, .o_move_accel, .o_move_decel, .o_table_number_out, .o_busy, .o_error,
    .o_gear_numerator_param, .o_gear_denominator_param);
  ptps_ctrl_model u_ctrl (.i_sys_clk, .o_auto_mode(i_auto_mode_select_in),
    .o_table_sel(i_table_select_in), .o_fwd(i_forward_start_in), .o_rev(i_reverse_start_in));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    do @(posedge i_sys_clk); while (o_s_axi_awready !== 1'b1);
    chk(o_s_axi_wready, 1'b1);
    i_s_axi_awvalid <= 1'b0;
    i_s_axi_wvalid <= 1'b0;
    i_s_axi_bready <= 1'b1;
    do @(posedge i_sys_clk); while (o_s_axi_bvalid !== 1'b1);
    chk(o_s_axi_bresp, er);
    i_s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    do @(posedge i_sys_clk); while (o_s_axi_arready !== 1'b1);
    i_s_axi_arvalid <= 1'b0;
    // A late rready lets the read data be seen standing
    repeat ($urandom % 3) @(posedge i_sys_clk);
    i_s_axi_rready <= 1'b1;
    do @(posedge i_sys_clk); while (o_s_axi_rvalid !== 1'b1);
    chk({o_s_axi_rresp, o_s_axi_rdata}, {er, e});
    i_s_axi_rready <= 1'b0;
  endtask
  // Filter fixed at 1 ms so pin timing stays short
  task automatic prm(input logic m, input logic [1:0] u, input logic [1:0] st, input logic rot);
    wr(12'h000, {12'h0, 4'h1, 3'h0, rot, 2'h0, st, 2'h0, u, 3'h0, m}, 2'h0);
    rd(12'h000, {12'h0, 4'h1, 3'h0, rot, 2'h0, st, 2'h0, u, 3'h0, m}, 2'h0);
  endtask
  task automatic ent(input logic [4:0] e, input logic [19:0] p, input logic [3:0] aux,
      input logic [15:0] dw);
    logic [11:0] a;
    a = 12'h200 + {e, 4'h0};
    sp_a[e] = 16'($urandom);
    ad_a[e] = $urandom;
    pos_a[e] = (p > 20'hf423f) ? 20'hf423f : p;
    wr(a, {12'h0, p}, 2'h0);
    wr(a + 12'h4, {16'h0, sp_a[e]}, 2'h0);
    wr(a + 12'h8, ad_a[e], 2'h0);
    wr(a + 12'hc, {12'h0, aux, dw}, 2'h0);
  endtask
  task automatic expect_mv(input logic [4:0] e, input logic ab, input logic inc,
      input logic [1:0] u, input logic [1:0] st, input logic rot, input int gp);
    logic [29:0] d;
    d = (u < 2'h2) ? pos_a[e] * (30'd10 ** st) : {10'h0, pos_a[e]};
    exp_q.push_back({d, ab, inc, inc ^ rot, u, sp_a[e], ad_a[e]});
    gap_q.push_back(gp);
  endtask
  // cnd packs auto, stopped, servo on, forward
  task automatic run(input logic [3:0] cnd, input logic [4:0] e);
    {i_motor_stopped, i_servo_on} <= cnd[2:1];
    u_ctrl.start(cnd[3], cnd[0], e);
    for (int k = 0; k < 3000 && (o_busy !== 1'b0 || exp_q.size() != 0); k++)
      @(posedge i_sys_clk);
    chk(exp_q.size(), 0);
  endtask

  // ****************************************
  // Clock, motion stub, monitor, watchdog
  // ****************************************
  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) cyc <= cyc + 1;
  initial begin
    forever begin
      @(posedge i_sys_clk);
      if (o_move_start === 1'b1) begin
        repeat (3 + $urandom % 8) @(posedge i_sys_clk);
        i_move_done <= 1'b1;
        done_cyc = cyc;
        @(posedge i_sys_clk);
        i_move_done <= 1'b0;
      end
    end
  end
  always @(posedge i_sys_clk) begin
    if (o_move_start === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(1, 0);
      end else begin
        chk(seen_mv, exp_q.pop_front());
        chk(cyc - done_cyc >= gap_q.pop_front(), 1);
      end
    end
  end
  initial begin
    repeat (80000) @(posedge i_sys_clk);
    miscompares++;
    summarize();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(97271));
    {i_rst_n, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid} = 5'h00;
    {i_s_axi_rready, i_motor_stopped, i_servo_on, i_move_done} = 4'h6;
    {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata, i_s_axi_wstrb} = '0;
    i_s_axi_wstrb = 4'hf;
    repeat (5) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    @(posedge i_sys_clk);
    rd(12'h000, 32'h0, 2'h0);
    rd(12'h004, 32'h1, 2'h0);
    rd(12'h008, 32'h1, 2'h0);
    rd(12'h010, 32'h0, 2'h2);
    wr(12'h010, 32'h5a5a_a5a5, 2'h2);
    g = $urandom;
    wr(12'h004, g, 2'h0);
    wr(12'h008, ~g, 2'h0);
    rd(12'h004, g, 2'h0);
    chk({o_gear_numerator_param, o_gear_denominator_param}, {g, ~g});
    for (int i = 0; i < 4; i++) begin
      s = 2'($urandom);
      prm(1'b0, 2'(i), s, i[0]);
      ent(5'd7, 20'($urandom % 1000000), 4'h0, 16'h0);
      expect_mv(5'd7, 1'b1, 1'b1, 2'(i), s, i[0], 0);
      run(4'b1111, 5'd7);
      chk(o_table_number_out, 4'h7);
    end
    foreach (refuse[i]) run(refuse[i], 5'd7);
    prm(1'b0, 2'h0, 2'h2, 1'b1);
    ent(5'd3, 20'($urandom % 1000000), 4'h1, 16'h2);
    ent(5'd4, 20'($urandom % 1000000), 4'h3, 16'h1);
    ent(5'd5, 20'hfffff, 4'h2, 16'h0);
    expect_mv(5'd3, 1'b1, 1'b1, 2'h0, 2'h2, 1'b1, 0);
    expect_mv(5'd4, 1'b0, 1'b1, 2'h0, 2'h2, 1'b1, MS);
    expect_mv(5'd5, 1'b0, 1'b1, 2'h0, 2'h2, 1'b1, 0);
    run(4'b1111, 5'd3);
    chk(o_table_number_out, 4'h5);
    prm(1'b1, 2'h2, 2'h1, 1'b1);
    ent(5'd9, 20'($urandom % 1000000), 4'h0, 16'h0);
    expect_mv(5'd9, 1'b0, 1'b1, 2'h2, 2'h1, 1'b1, 0);
    run(4'b1111, 5'd9);
    prm(1'b1, 2'h3, 2'h3, 1'b0);
    ent(5'd29, 20'($urandom % 1000000), 4'h1, 16'h1);
    ent(5'd30, 20'($urandom % 1000000), 4'h1, 16'h0);
    ent(5'd31, 20'($urandom % 1000000), 4'h1, 16'h0);
    expect_mv(5'd29, 1'b0, 1'b0, 2'h3, 2'h3, 1'b0, 0);
    expect_mv(5'd30, 1'b0, 1'b0, 2'h3, 2'h3, 1'b0, 0);
    run(4'b1110, 5'd29);
    chk({o_error, o_table_number_out}, {1'b1, 4'he});
    rd(12'h00c, 32'h0001_1f04, 2'h0);
    summarize();
  end
endmodule
